//--- pkg/drive_regs_pkg.sv
// Package: register map, field positions and setting encodings for the drive command bank
package drive_regs_pkg;

    // Register indices (word addresses)
    localparam logic [15:0] ADDR_FREQ_REF     = 16'h0380;
    localparam logic [15:0] ADDR_SPEED_REF    = 16'h0381;
    localparam logic [15:0] ADDR_RUN_WORD     = 16'h0382;
    localparam logic [15:0] ADDR_RAMP_UP      = 16'h0383;
    localparam logic [15:0] ADDR_RAMP_DOWN    = 16'h0384;
    localparam logic [15:0] ADDR_OUT_TERM     = 16'h0386;
    localparam logic [15:0] ADDR_LOOP_SET     = 16'h0388;
    localparam logic [15:0] ADDR_LOOP_FB      = 16'h0389;
    localparam logic [15:0] ADDR_MOTOR_CURR   = 16'h038A;
    localparam logic [15:0] ADDR_VOLT_CLASS   = 16'h038B;
    localparam logic [15:0] ADDR_TRQ_SET      = 16'h0390;
    localparam logic [15:0] ADDR_TRQ_LIM_FM   = 16'h0391;
    localparam logic [15:0] ADDR_TRQ_LIM_FR   = 16'h0392;
    localparam logic [15:0] ADDR_TRQ_LIM_RM   = 16'h0393;
    localparam logic [15:0] ADDR_TRQ_LIM_RR   = 16'h0394;
    localparam logic [15:0] ADDR_TRQ_OFFSET   = 16'h0395;

    // Run word fields
    localparam int RUN_BIT    = 0;
    localparam int DIR_BIT    = 1;
    localparam int RESET_BIT  = 2;
    localparam int COAST_BIT  = 3;

    // Output terminal fields
    localparam int CONTACT1_BIT = 5;
    localparam int CONTACT2_BIT = 4;
    localparam int TRANS1_BIT   = 3;
    localparam int TRANS2_BIT   = 2;
    localparam int TRANS3_BIT   = 1;
    localparam logic [15:0] OUT_TERM_MASK = 16'h003E;
    localparam logic [15:0] RUN_RD_MASK   = 16'h0003;

    // Voltage class answers
    localparam logic [15:0] VOLT_CLASS_200 = 16'h00C8;
    localparam logic [15:0] VOLT_CLASS_400 = 16'h0190;

    // Reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Source selection and control mode settings
    typedef enum logic [0:0] {
        SRC_OTHER,
        SRC_COMM
    } source_t;

    typedef enum logic [0:0] {
        MODE_SPEED,
        MODE_TORQUE
    } control_mode_t;

    typedef struct packed {
        source_t       run_source_select;
        source_t       speed_source_select;
        control_mode_t control_mode_select;
        source_t       torque_setpoint_source;
        source_t       torque_limit_source;
        source_t       torque_offset_source;
    } config_t;

    typedef struct packed {
        logic [15:0] fwd_motoring;
        logic [15:0] fwd_regen;
        logic [15:0] rev_motoring;
        logic [15:0] rev_regen;
    } torque_limits_t;

    typedef struct packed {
        logic contact_output_one;
        logic contact_output_two;
        logic transistor_output_one;
        logic transistor_output_two;
        logic transistor_output_three;
    } terminals_t;

endpackage

//--- rtl/drive_comm_command_registers.sv
// Communication-reachable command and status word bank of a motor drive
//
// Contract
// - Frequency word is unsigned, 0.01 Hz per step; 1000 means 10 Hz.
// - Speed word is 1 rpm per step, used only with comm speed source.
// - Run word bit 0: set runs, clear stops.
// - Run word bit 1: set forward, clear reverse.
// - Run word bit 3 rising edge coasts drive to stop, output removed.
// - Run word bit 2 rising edge clears the present trip.
// - Coast and trip-reset bits are write-only and read back zero.
// - Run word acted on only when run source selects comm path; forward_select still follows stored bit 1 whatever the source.
// - Terminal word: contact outputs bits 5,4; transistor outputs bits 3,2,1.
// - Voltage class word is read-only, returns 200 or 400.
// - Torque setpoint writable only in torque mode with comm torque source.
// - Four torque limits writable only with comm limit source, else read-only.
// - Torque limits coded in 0.1 percent steps.
// - Torque offset changes only when its source selects comm path.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

module drive_comm_command_registers #(
    parameter logic HIGH_VOLTAGE_UNIT = 1'b0
) (
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           nrst,
    // Register port
    input  wire logic [15:0]                    addr,
    input  wire logic [15:0]                    wdata,
    input  wire logic                           wr,
    input  wire logic                           rd,
    output logic [15:0]                         rdata,
    // Drive settings, from same clock domain
    input  wire drive_regs_pkg::config_t        cfg,
    // Commands to the drive core
    output logic [15:0]                         freq_command,
    output logic [15:0]                         speed_command,
    output logic                                run_request,
    output logic                                forward_select,
    output logic                                coast_stop_request,
    output logic                                trip_clear,
    output logic [15:0]                         ramp_up_command,
    output logic [15:0]                         ramp_down_command,
    output drive_regs_pkg::terminals_t          terminals,
    output logic [15:0]                         loop_setpoint_command,
    output logic [15:0]                         loop_feedback_command,
    output logic [15:0]                         motor_current_parameter,
    output logic [15:0]                         torque_command,
    output drive_regs_pkg::torque_limits_t      torque_limits,
    output logic [15:0]                         torque_offset_command
);

    // Stored words
    logic [15:0]                    freq_q, freq_d;
    logic [15:0]                    speed_q, speed_d;
    logic [15:0]                    speed_out_q, speed_out_d;
    logic [1:0]                     run_q, run_d;
    logic [15:0]                    rup_q, rup_d;
    logic [15:0]                    rdn_q, rdn_d;
    logic [15:0]                    term_q, term_d;
    logic [15:0]                    lset_q, lset_d;
    logic [15:0]                    lfb_q, lfb_d;
    logic [15:0]                    mcur_q, mcur_d;
    logic [15:0]                    trq_q, trq_d;
    drive_regs_pkg::torque_limits_t lim_q, lim_d;
    logic [15:0]                    toff_q, toff_d;
    logic [15:0]                    rdata_q, rdata_d;
    logic                           coast_q, coast_d;
    logic                           clr_q, clr_d;
    logic                           run_out_q, run_out_d;
    logic                           fwd_out_q, fwd_out_d;

    // Write strobe for one register index
    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction

    logic run_comm;
    assign run_comm = (cfg.run_source_select == drive_regs_pkg::SRC_COMM);

    logic speed_comm;
    assign speed_comm = (cfg.speed_source_select == drive_regs_pkg::SRC_COMM);

    // Register writes with source gating
    always_comb
    begin
        freq_d  = freq_q;
        speed_d = speed_q;
        run_d   = run_q;
        rup_d   = rup_q;
        rdn_d   = rdn_q;
        term_d  = term_q;
        lset_d  = lset_q;
        lfb_d   = lfb_q;
        mcur_d  = mcur_q;
        trq_d   = trq_q;
        lim_d   = lim_q;
        toff_d  = toff_q;
        coast_d = 1'b0;
        clr_d   = 1'b0;
        if (wr)
        begin
            if (hit(addr, drive_regs_pkg::ADDR_FREQ_REF))
                freq_d = wdata;
            if (hit(addr, drive_regs_pkg::ADDR_SPEED_REF))
                speed_d = wdata;
            if (hit(addr, drive_regs_pkg::ADDR_RUN_WORD) && run_comm)
            begin
                run_d = wdata[1:0];
                // written 0 to 1 on coast bit
                coast_d = wdata[drive_regs_pkg::COAST_BIT];
                // written 0 to 1 on reset bit
                clr_d = wdata[drive_regs_pkg::RESET_BIT];
            end
            if (hit(addr, drive_regs_pkg::ADDR_RAMP_UP))
                rup_d = wdata;
            if (hit(addr, drive_regs_pkg::ADDR_RAMP_DOWN))
                rdn_d = wdata;
            if (hit(addr, drive_regs_pkg::ADDR_OUT_TERM))
                term_d = wdata & drive_regs_pkg::OUT_TERM_MASK;
            if (hit(addr, drive_regs_pkg::ADDR_LOOP_SET))
                lset_d = wdata;
            if (hit(addr, drive_regs_pkg::ADDR_LOOP_FB))
                lfb_d = wdata;
            if (hit(addr, drive_regs_pkg::ADDR_MOTOR_CURR))
                mcur_d = wdata;
            if (hit(addr, drive_regs_pkg::ADDR_TRQ_SET)
                && cfg.control_mode_select == drive_regs_pkg::MODE_TORQUE
                && cfg.torque_setpoint_source == drive_regs_pkg::SRC_COMM)
                trq_d = wdata;
            // limits in 0.1 percent, comm source only
            if (cfg.torque_limit_source == drive_regs_pkg::SRC_COMM)
            begin
                if (hit(addr, drive_regs_pkg::ADDR_TRQ_LIM_FM))
                    lim_d.fwd_motoring = wdata;
                if (hit(addr, drive_regs_pkg::ADDR_TRQ_LIM_FR))
                    lim_d.fwd_regen = wdata;
                if (hit(addr, drive_regs_pkg::ADDR_TRQ_LIM_RM))
                    lim_d.rev_motoring = wdata;
                if (hit(addr, drive_regs_pkg::ADDR_TRQ_LIM_RR))
                    lim_d.rev_regen = wdata;
            end
            // offset changes on comm source only
            if (hit(addr, drive_regs_pkg::ADDR_TRQ_OFFSET)
                && cfg.torque_offset_source == drive_regs_pkg::SRC_COMM)
                toff_d = wdata;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            freq_q  <= drive_regs_pkg::WORD_RESET;
            speed_q <= drive_regs_pkg::WORD_RESET;
            run_q   <= 2'h0;
            rup_q   <= drive_regs_pkg::WORD_RESET;
            rdn_q   <= drive_regs_pkg::WORD_RESET;
            term_q  <= drive_regs_pkg::WORD_RESET;
            lset_q  <= drive_regs_pkg::WORD_RESET;
            lfb_q   <= drive_regs_pkg::WORD_RESET;
            mcur_q  <= drive_regs_pkg::WORD_RESET;
            trq_q   <= drive_regs_pkg::WORD_RESET;
            lim_q   <= '0;
            toff_q  <= drive_regs_pkg::WORD_RESET;
            coast_q <= 1'b0;
            clr_q   <= 1'b0;
        end
        else
        begin
            freq_q  <= freq_d;
            speed_q <= speed_d;
            run_q   <= run_d;
            rup_q   <= rup_d;
            rdn_q   <= rdn_d;
            term_q  <= term_d;
            lset_q  <= lset_d;
            lfb_q   <= lfb_d;
            mcur_q  <= mcur_d;
            trq_q   <= trq_d;
            lim_q   <= lim_d;
            toff_q  <= toff_d;
            coast_q <= coast_d;
            clr_q   <= clr_d;
        end
    end

    // Read mux; one cycle latency, unmapped reads zero
    always_comb
    begin
        rdata_d = 16'h0000;
        if (rd)
        begin
            unique case (addr)
                drive_regs_pkg::ADDR_FREQ_REF:   rdata_d = freq_q;
                drive_regs_pkg::ADDR_SPEED_REF:  rdata_d = speed_q;
                // coast and reset bits read zero
                drive_regs_pkg::ADDR_RUN_WORD:
                    rdata_d = {14'h0000, run_q} & drive_regs_pkg::RUN_RD_MASK;
                drive_regs_pkg::ADDR_RAMP_UP:    rdata_d = rup_q;
                drive_regs_pkg::ADDR_RAMP_DOWN:  rdata_d = rdn_q;
                drive_regs_pkg::ADDR_OUT_TERM:   rdata_d = term_q;
                drive_regs_pkg::ADDR_LOOP_SET:   rdata_d = lset_q;
                drive_regs_pkg::ADDR_LOOP_FB:    rdata_d = lfb_q;
                drive_regs_pkg::ADDR_MOTOR_CURR: rdata_d = mcur_q;
                drive_regs_pkg::ADDR_VOLT_CLASS:
                    rdata_d = HIGH_VOLTAGE_UNIT ? drive_regs_pkg::VOLT_CLASS_400
                                                : drive_regs_pkg::VOLT_CLASS_200;
                drive_regs_pkg::ADDR_TRQ_SET:    rdata_d = trq_q;
                drive_regs_pkg::ADDR_TRQ_LIM_FM: rdata_d = lim_q.fwd_motoring;
                drive_regs_pkg::ADDR_TRQ_LIM_FR: rdata_d = lim_q.fwd_regen;
                drive_regs_pkg::ADDR_TRQ_LIM_RM: rdata_d = lim_q.rev_motoring;
                drive_regs_pkg::ADDR_TRQ_LIM_RR: rdata_d = lim_q.rev_regen;
                drive_regs_pkg::ADDR_TRQ_OFFSET: rdata_d = toff_q;
                default:                         rdata_d = 16'h0000;
            endcase
        end
    end

    // Command outputs track the next stored word, so they land with the write;
    // run and speed held at zero while comm does not own the matching source; forward never gated
    always_comb
    begin
        run_out_d   = run_comm & run_d[drive_regs_pkg::RUN_BIT];
        fwd_out_d   = run_d[drive_regs_pkg::DIR_BIT];
        speed_out_d = speed_comm ? speed_d : drive_regs_pkg::WORD_RESET;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q     <= 16'h0000;
            run_out_q   <= 1'b0;
            fwd_out_q   <= 1'b0;
            speed_out_q <= drive_regs_pkg::WORD_RESET;
        end
        else
        begin
            rdata_q     <= rdata_d;
            run_out_q   <= run_out_d;
            fwd_out_q   <= fwd_out_d;
            speed_out_q <= speed_out_d;
        end
    end

    // Outputs straight from flops
    assign rdata                 = rdata_q;
    assign freq_command          = freq_q;
    // speed word only reaches core on comm source
    assign speed_command         = speed_out_q;
    assign run_request           = run_out_q;
    assign forward_select        = fwd_out_q;
    assign coast_stop_request    = coast_q;
    assign trip_clear            = clr_q;
    assign ramp_up_command       = rup_q;
    assign ramp_down_command     = rdn_q;
    assign terminals.contact_output_one      = term_q[drive_regs_pkg::CONTACT1_BIT];
    assign terminals.contact_output_two      = term_q[drive_regs_pkg::CONTACT2_BIT];
    assign terminals.transistor_output_one   = term_q[drive_regs_pkg::TRANS1_BIT];
    assign terminals.transistor_output_two   = term_q[drive_regs_pkg::TRANS2_BIT];
    assign terminals.transistor_output_three = term_q[drive_regs_pkg::TRANS3_BIT];
    assign loop_setpoint_command   = lset_q;
    assign loop_feedback_command   = lfb_q;
    assign motor_current_parameter = mcur_q;
    assign torque_command          = trq_q;
    assign torque_limits           = lim_q;
    assign torque_offset_command   = toff_q;

endmodule

//--- test/drive_cmd_props.sv
// Checker: timing properties of the drive command word bank
`timescale 1ns/1ps
module drive_cmd_props #(
    parameter logic HIGH_VOLTAGE_UNIT = 1'b0
) (
    // Clock and reset
    input wire logic                           clock,
    input wire logic                           nrst,
    // Register port
    input wire logic [15:0]                    addr,
    input wire logic [15:0]                    wdata,
    input wire logic                           wr,
    input wire logic                           rd,
    input wire logic [15:0]                    rdata,
    // Settings and commands
    input wire drive_regs_pkg::config_t        cfg,
    input wire logic [15:0]                    freq_command,
    input wire logic                           run_request,
    input wire logic                           coast_stop_request,
    input wire logic                           trip_clear,
    input wire drive_regs_pkg::terminals_t     terminals,
    input wire logic [15:0]                    torque_command,
    input wire drive_regs_pkg::torque_limits_t torque_limits
);
    // Single domain, so one clocking and one reset for every property
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Decoded accesses; run writes count only with the comm run source
    logic        run_ok;
    logic        trq_shut;
    logic        lim_shut;
    logic [15:0] volt_exp;
    assign run_ok = wr && addr == drive_regs_pkg::ADDR_RUN_WORD
                    && cfg.run_source_select == drive_regs_pkg::SRC_COMM;
    assign trq_shut = cfg.control_mode_select != drive_regs_pkg::MODE_TORQUE
                      || cfg.torque_setpoint_source != drive_regs_pkg::SRC_COMM;
    assign lim_shut = wr && addr >= drive_regs_pkg::ADDR_TRQ_LIM_FM
                      && addr <= drive_regs_pkg::ADDR_TRQ_LIM_RR
                      && cfg.torque_limit_source == drive_regs_pkg::SRC_OTHER;
    assign volt_exp = HIGH_VOLTAGE_UNIT ? drive_regs_pkg::VOLT_CLASS_400
                                        : drive_regs_pkg::VOLT_CLASS_200;
    freq_word_a: assert property (wr && addr == drive_regs_pkg::ADDR_FREQ_REF |=>
        freq_command == $past(wdata)) else $error("frequency word not taken");
    run_bit_a: assert property (run_ok |=> run_request == $past(wdata[0]))
        else $error("run request does not follow bit zero");
    coast_pulse_a: assert property (coast_stop_request |-> $past(run_ok && wdata[3]))
        else $error("coast pulse without its write");
    trip_pulse_a: assert property (trip_clear |-> $past(run_ok && wdata[2]))
        else $error("trip clear pulse without its write");
    run_gate_a: assert property (cfg.run_source_select == drive_regs_pkg::SRC_OTHER |=>
        !run_request) else $error("run request while run source is elsewhere");
    run_read_a: assert property (rd && addr == drive_regs_pkg::ADDR_RUN_WORD |=>
        rdata[3:2] == 2'h0) else $error("write-only run bits read back");
    term_map_a: assert property (wr && addr == drive_regs_pkg::ADDR_OUT_TERM |=>
        terminals == $past(wdata[5:1])) else $error("terminal bits misplaced");
    volt_class_a: assert property (rd && addr == drive_regs_pkg::ADDR_VOLT_CLASS |=>
        rdata == volt_exp) else $error("voltage class wrong");
    trq_gate_a: assert property (wr && addr == drive_regs_pkg::ADDR_TRQ_SET && trq_shut |=>
        $stable(torque_command)) else $error("torque setpoint taken while locked");
    lim_gate_a: assert property (lim_shut |=> $stable(torque_limits))
        else $error("torque limit taken while locked");
    // Main scenarios reached
    cover property (coast_stop_request);
    cover property (trip_clear);
    cover property (run_ok ##1 run_request);
endmodule

//--- test/comm_master_model.sv
// Bus master model standing in for the serial or fieldbus controller
`timescale 1ns/1ps
module comm_master_model (
    // Clock
    input  wire logic        clock,
    // Register port
    output logic      [15:0] addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    // Idle bus shows junk, never the last word
    initial
    begin
        addr = 16'hFFFF;
        wdata = 16'hFFFF;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One write cycle; returns just after the edge that takes it
    task automatic write_word(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        addr <= ~a;
        wdata <= ~d;
        wr <= 1'b0;
    endtask
    // One read cycle; data stand only in the following cycle
    task automatic read_word(input logic [15:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        addr <= ~a;
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule

//--- test/drive_comm_command_registers_bench.sv
// Self-checking bench for the drive command word bank
`timescale 1ns/1ps
module drive_comm_command_registers_bench;
    logic                           clock = 1'b0;
    logic                           nrst = 1'b0;
    logic [15:0]                    addr, wdata, rdata;
    logic                           wr, rd;
    drive_regs_pkg::config_t        cfg = drive_regs_pkg::config_t'(6'h3F);
    logic [15:0]                    freq_command, speed_command, ramp_up_command;
    logic [15:0]                    ramp_down_command, loop_setpoint_command;
    logic [15:0]                    loop_feedback_command, motor_current_parameter;
    logic [15:0]                    torque_command, torque_offset_command;
    logic                           run_request, forward_select, coast_stop_request, trip_clear;
    drive_regs_pkg::terminals_t     terminals;
    drive_regs_pkg::torque_limits_t torque_limits;
    int                             error_cnt = 0;
    int                             tests_run = 0;
    // Design and far-side master
    drive_comm_command_registers dut (.*);
    comm_master_model bus (.*);
    // Clock, 8 ns period
    always #4 clock = ~clock;
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_check(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        bus.read_word(a, d);
        check(d, exp);
    endtask
    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Readback of an address: masks, fixed class and reserved holes
    function automatic logic [15:0] expect_rd(input logic [15:0] a, input logic [15:0] d);
        if (a == drive_regs_pkg::ADDR_RUN_WORD)
            return d & drive_regs_pkg::RUN_RD_MASK;
        if (a == drive_regs_pkg::ADDR_OUT_TERM)
            return d & drive_regs_pkg::OUT_TERM_MASK;
        if (a == drive_regs_pkg::ADDR_VOLT_CLASS)
            return drive_regs_pkg::VOLT_CLASS_200;
        if (a inside {16'h0385, 16'h0387, [16'h038C:16'h038F]} || a > 16'h0395)
            return 16'h0000;
        return d;
    endfunction
    // Hang guard: a stuck run still ends with a verdict
    initial
    begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        logic [15:0] a;
        logic [15:0] d;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        // Sweep the whole window, reserved holes included, all gates open
        for (int i = 0; i < 24; i++)
        begin
            a = 16'h0380 + 16'(i);
            d = 16'h5A3F + 16'(i);
            bus.write_word(a, d);
            rd_check(a, expect_rd(a, d));
        end
        bus.write_word(drive_regs_pkg::ADDR_FREQ_REF, 16'h03E8);
        #1 check(freq_command, 16'h03E8);
        check({speed_command, ramp_up_command, ramp_down_command}, 48'h5A40_5A42_5A43);
        check({loop_setpoint_command, loop_feedback_command}, 32'h5A47_5A48);
        check(motor_current_parameter, 16'h5A49);
        // Run, forward, coast and trip in one word; pulses last one cycle
        bus.write_word(drive_regs_pkg::ADDR_RUN_WORD, 16'h000F);
        #1 check({run_request, forward_select, coast_stop_request, trip_clear}, 4'hF);
        @(posedge clock) #1 check({coast_stop_request, trip_clear}, 2'h0);
        rd_check(drive_regs_pkg::ADDR_RUN_WORD, 16'h0003);
        bus.write_word(drive_regs_pkg::ADDR_RUN_WORD, 16'h0001);
        #1 check({run_request, forward_select}, 2'h2);
        // Run and speed sources moved away: drive stops, speed held at zero
        @(posedge clock) cfg <= drive_regs_pkg::config_t'(6'h0F);
        bus.write_word(drive_regs_pkg::ADDR_RUN_WORD, 16'h000F);
        #1 check({run_request, coast_stop_request, trip_clear}, 3'h0);
        check(speed_command, 16'h0000);
        // Walk one terminal bit at a time
        for (int k = 1; k < 6; k++)
        begin
            bus.write_word(drive_regs_pkg::ADDR_OUT_TERM, 16'h0001 << k);
            #1 check(terminals, 5'h01 << (k - 1));
        end
        // Torque words locked by mode or by source: sweep values stay
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clock) cfg <= drive_regs_pkg::config_t'(j == 0 ? 6'h34 : 6'h38);
            bus.write_word(drive_regs_pkg::ADDR_TRQ_SET, 16'h1111);
            bus.write_word(drive_regs_pkg::ADDR_TRQ_LIM_RR, 16'h2222);
            bus.write_word(drive_regs_pkg::ADDR_TRQ_OFFSET, 16'h3333);
            #1 check(torque_command, 16'h5A4F);
            check(torque_limits, 64'h5A50_5A51_5A52_5A53);
            check(torque_offset_command, 16'h5A54);
            rd_check(drive_regs_pkg::ADDR_TRQ_LIM_RR, 16'h5A53);
        end
        print_verdict();
    end
endmodule

bind drive_comm_command_registers drive_cmd_props #(.HIGH_VOLTAGE_UNIT(HIGH_VOLTAGE_UNIT)) props (.*);
